// *** logic/eqdc_defs.svh ***
// Purpose: constants of the error queue and device clear block
// Assumes: included by bare name
// Notes: definitions only
`ifndef EQDC_DEFS_SVH
`define EQDC_DEFS_SVH
`define EQDC_DEPTH 20
`define EQDC_CODE_W 16
`define EQDC_OVF_CODE 16'shFEA2
`define EQDC_NOERR_CODE 16'sh0000
`define EQDC_TEXT_MAX 8'h50
`define EQDC_CTRLC 8'h03
`endif

// *** logic/eqdc_pkg.sv ***
// Purpose: shared types of the error queue block
// Assumes: nothing
// Notes: state of the command input path
package eqdc_pkg;
  typedef enum logic [1:0] {
    EQDC_IDLE = 2'b00,
    EQDC_RECV = 2'b01,
    EQDC_EXEC = 2'b11
  } eqdc_parse_e;
  typedef logic signed [15:0] eqdc_code_t;
endpackage : eqdc_pkg

// *** logic/eqdc_mem.sv ***
// Purpose: record storage for the error queue
// Assumes: one write and one read port, same clock
// Notes: read data come out of a register
`timescale 1ns/100ps
module eqdc_mem #(
  parameter int DEPTH = 20,
  parameter int WIDTH = 16,
  parameter int AW = 5
) (
  input wire logic ref_clk,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [AW-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);
  logic [WIDTH-1:0] mem [DEPTH];
  always_ff @(posedge ref_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule : eqdc_mem

// *** logic/eqdc_sync.sv ***
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: asynchronous active high reset
// Notes: first stage read only by the second
`timescale 1ns/100ps
module eqdc_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : eqdc_sync

// *** logic/eqdc_top.sv ***
// Purpose: error queue, beep pulse and device clear of an instrument
// Assumes: single clock ref_clk, pins synchronised here
// Notes: queue is untouched by device clear and by the reset command
`timescale 1ns/100ps
`include "eqdc_defs.svh"
module eqdc_top import eqdc_pkg::*; #(
  parameter int DEPTH = `EQDC_DEPTH
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic errPush,
  input wire logic [15:0] errCode,
  input wire logic errPop,
  input wire logic clrStatus,
  input wire logic rstCmd,
  input wire logic busDevClr,
  input wire logic serialMode,
  input wire logic rxValid,
  input wire logic [7:0] rxChar,
  input wire logic cmdStart,
  input wire logic cmdDone,
  output logic popValid_q,
  output logic [15:0] popCode_q,
  output logic [7:0] textMaxLen_q,
  output logic errLed_q,
  output logic beep_q,
  output logic inBufFlush_q,
  output logic outBufFlush_q,
  output logic dtrOut_q,
  output logic [1:0] parseState_q,
  output logic [4:0] errCount_q
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

  ////////////////////////////////////////////////////////////////////////
  // pin inputs: bus clear line passes two flip-flops
  logic busDevClrSync;
  logic busDevClrDly_q;
  eqdc_sync #(.W(1)) uSync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .din(busDevClr),
    .dout(busDevClrSync)
  );
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busDevClrDly_q <= 1'b0;
    end else begin
      busDevClrDly_q <= busDevClrSync;
    end
  end

  logic busClrEvt;
  logic ctrlCEvt;
  logic devClr;
  assign busClrEvt = busDevClrSync & ~busDevClrDly_q;
  // the serial character only clears while the serial link is selected
  assign ctrlCEvt = serialMode & rxValid & (rxChar == `EQDC_CTRLC);
  assign devClr = busClrEvt | ctrlCEvt;

  ////////////////////////////////////////////////////////////////////////
  // device clear effects; queue and status have no devClr term
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      inBufFlush_q <= 1'b0;
      outBufFlush_q <= 1'b0;
    end else begin
      inBufFlush_q <= devClr;
      outBufFlush_q <= devClr;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dtrOut_q <= 1'b0;
    end else if (devClr) begin
      dtrOut_q <= 1'b1;
    end
  end

  eqdc_parse_e parse_d;
  eqdc_parse_e parse_q;
  always_comb begin
    parse_d = parse_q;
    case (parse_q)
      EQDC_IDLE: begin
        if (cmdStart) begin
          parse_d = EQDC_RECV;
        end
      end
      EQDC_RECV: begin
        if (cmdDone) begin
          parse_d = EQDC_EXEC;
        end
      end
      EQDC_EXEC: begin
        parse_d = EQDC_IDLE;
      end
      default: begin
        parse_d = EQDC_IDLE;
      end
    endcase
    if (devClr) begin
      parse_d = EQDC_IDLE;
    end
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      parse_q <= EQDC_IDLE;
    end else begin
      parse_q <= parse_d;
    end
  end
  assign parseState_q = parse_q;

  ////////////////////////////////////////////////////////////////////////
  // error queue
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  logic [AW-1:0] lastPtr_q;
  logic ovfLock_q;
  logic doPop;
  logic full;
  logic doPush;
  logic doOvf;
  logic memWr;
  logic [AW-1:0] memAddr;
  logic [15:0] memData;
  logic [15:0] memRd;
  logic popPend_q;

  // rstCmd is deliberately unused by the queue
  assign doPop = errPop & (count_q != '0);
  // a same-cycle pop frees a slot before the push is judged
  assign full = (count_q == DEPTH_C) & ~doPop;
  assign doPush = errPush & ~full & ~ovfLock_q & ~clrStatus;
  assign doOvf = errPush & full & ~ovfLock_q & ~clrStatus;
  assign memWr = doPush | doOvf;
  assign memAddr = doOvf ? lastPtr_q : wrPtr_q;
  assign memData = doOvf ? `EQDC_OVF_CODE : errCode;

  eqdc_mem #(.DEPTH(DEPTH), .WIDTH(`EQDC_CODE_W), .AW(AW)) uMem (
    .ref_clk(ref_clk),
    .wrEn(memWr),
    .wrAddr(memAddr),
    .wrData(memData),
    .rdAddr(rdPtr_q),
    .rdData(memRd)
  );

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      lastPtr_q <= '0;
    end else if (clrStatus) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (doPop) begin
        rdPtr_q <= (rdPtr_q == LAST_C) ? '0 : rdPtr_q + 1'b1;
      end
      if (doPush) begin
        wrPtr_q <= (wrPtr_q == LAST_C) ? '0 : wrPtr_q + 1'b1;
        lastPtr_q <= wrPtr_q;
      end
      if (doPush & ~doPop) begin
        count_q <= count_q + 1'b1;
      end else if (doPop & ~doPush) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  // overflow lock holds until a read frees a slot or clrStatus empties the queue
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ovfLock_q <= 1'b0;
    end else if (clrStatus | doPop) begin
      ovfLock_q <= 1'b0;
    end else if (doOvf) begin
      ovfLock_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read answer: memory read is registered, so answer two cycles after the pop
  logic popEmpty_q;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      popPend_q <= 1'b0;
      popEmpty_q <= 1'b0;
    end else begin
      popPend_q <= errPop & ~clrStatus;
      popEmpty_q <= (count_q == '0);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      popValid_q <= 1'b0;
      popCode_q <= `EQDC_NOERR_CODE;
    end else begin
      popValid_q <= popPend_q;
      if (popPend_q) begin
        popCode_q <= popEmpty_q ? `EQDC_NOERR_CODE : memRd;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      textMaxLen_q <= `EQDC_TEXT_MAX;
    end else begin
      textMaxLen_q <= `EQDC_TEXT_MAX;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // indicator and beep
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      errLed_q <= 1'b0;
      errCount_q <= '0;
    end else begin
      errLed_q <= (count_q != '0);
      errCount_q <= 5'(count_q);
    end
  end

  // every generated error beeps, stored or dropped
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      beep_q <= 1'b0;
    end else begin
      beep_q <= errPush;
    end
  end
endmodule : eqdc_top

// *** testbench/eqdc_ctl_model.sv ***
// Purpose: bus controller model
// Assumes: one query at a time
// Notes: got keeps the last answer
`timescale 1ns/100ps
module eqdc_ctl_model (
  input wire logic ref_clk,
  input wire logic req,
  input wire logic popValid_q,
  input wire logic [15:0] popCode_q,
  output logic errPop = 1'b0,
  output logic done = 1'b0,
  output logic [15:0] got = 16'h0
);
  logic busy = 1'b0;
  // no new query until the last one is answered
  always @(posedge ref_clk) begin
    errPop <= req && !busy;
    if (req) begin
      busy <= 1'b1;
      done <= 1'b0;
    end
    if (popValid_q) begin
      got <= popCode_q;
      done <= 1'b1;
      busy <= 1'b0;
    end
  end
endmodule : eqdc_ctl_model

// *** testbench/eqdc_chk.sv ***
// Purpose: port checks of the error queue
// Assumes: bound to eqdc_top
// Notes: design ports only, inputs and outputs
`timescale 1ns/100ps
module eqdc_chk #(
  parameter int DEPTH = 20
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic errPush,
  input wire logic errPop,
  input wire logic clrStatus,
  input wire logic popValid_q,
  input wire logic errLed_q,
  input wire logic beep_q,
  input wire logic inBufFlush_q,
  input wire logic outBufFlush_q,
  input wire logic dtrOut_q,
  input wire logic [1:0] parseState_q,
  input wire logic [4:0] errCount_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_beep_per_push: assert property (errPush |=> beep_q)
    else $error("no beep");
  a_beep_cause: assert property (beep_q |-> $past(errPush))
    else $error("stray beep");
  a_pop_answer: assert property (errPop && !clrStatus |-> ##2 popValid_q)
    else $error("no answer");
  a_led_count: assert property (errLed_q == (errCount_q != 5'h0))
    else $error("led wrong");
  a_count_max: assert property (errCount_q <= DEPTH)
    else $error("too many");
  a_flush_both: assert property (inBufFlush_q == outBufFlush_q)
    else $error("flush split");
  a_dtr_set: assert property (inBufFlush_q |-> ##[0:1] dtrOut_q)
    else $error("dtr low");
  a_dtr_holds: assert property (dtrOut_q |=> dtrOut_q)
    else $error("dtr fell");
  a_idle_clear: assert property (inBufFlush_q |-> ##[0:1] parseState_q == 2'h0)
    else $error("not idle");
  c_full: cover property (errCount_q == DEPTH);
  c_pop: cover property (popValid_q);
  c_clear: cover property (inBufFlush_q);
endmodule : eqdc_chk
bind eqdc_top eqdc_chk #(.DEPTH(DEPTH)) chk (.*);

// *** testbench/testbench.sv ***
// Purpose: self-checking bench of the error queue
// Assumes: default depth of 20
// Notes: queries go through the controller model
`timescale 1ns/100ps
module testbench;
  logic ref_clk, sys_rst, errPush, errPop, clrStatus, rstCmd, busDevClr;
  logic serialMode, rxValid, cmdStart, cmdDone, req, done;
  logic popValid_q, errLed_q, beep_q, inBufFlush_q, outBufFlush_q, dtrOut_q;
  logic [15:0] errCode, popCode_q, got;
  logic [7:0] rxChar, textMaxLen_q;
  logic [1:0] parseState_q;
  logic [4:0] errCount_q;
  int n_mismatch = 0;
  int comparisons = 0;
  eqdc_top DUT (.*);
  eqdc_ctl_model ctl (.*);
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // back to back pushes keep the strobe high between codes
  task automatic push(input logic [15:0] c, input int n);
    errPush = 1'b1;
    repeat (n) begin
      errCode = c;
      c++;
      tick();
    end
    errPush = 1'b0;
  endtask : push
  task automatic pop_chk(input logic [15:0] e);
    int i;
    req = 1'b1;
    tick();
    req = 1'b0;
    for (i = 0; i < 8 && done !== 1'b1; i++) tick();
    chk("popCode", e, got);
    if (done !== 1'b1) begin
      // a query that is never answered is a failure in its own right
      n_mismatch++;
      tally_and_finish();
    end
  endtask : pop_chk
  task automatic wait_flush();
    int i;
    for (i = 0; i < 8 && inBufFlush_q !== 1'b1; i++) tick();
    chk("outFlush", 1, 16'(outBufFlush_q));
    if (i == 8) tally_and_finish();
  endtask : wait_flush
  ////////////////////////////////////////////////////////////////
  task automatic s_fifo();
    push(16'hFF8F, 1);
    chk("beep", 1, 16'(beep_q));
    tick();
    chk("beep", 0, 16'(beep_q));
    chk("led", 1, 16'(errLed_q));
    push(16'hFF9A, 1);
    pop_chk(16'hFF8F);
    pop_chk(16'hFF9A);
    chk("led", 0, 16'(errLed_q));
  endtask : s_fifo
  task automatic s_overflow();
    int i;
    push(16'h0001, 22);
    tick();
    tick();
    chk("count", 20, 16'(errCount_q));
    pop_chk(16'h0001);
    push(16'h0063, 1);
    for (i = 2; i < 20; i++) pop_chk(16'(i));
    pop_chk(16'hFEA2);
    pop_chk(16'h0063);
    pop_chk(16'h0000);
    chk("count", 0, 16'(errCount_q));
  endtask : s_overflow
  task automatic s_clear();
    push(16'hFF9B, 2);
    cmdStart = 1'b1;
    tick();
    cmdStart = 1'b0;
    busDevClr = 1'b1;
    wait_flush();
    tick();
    chk("dtr", 1, 16'(dtrOut_q));
    chk("parse", 0, 16'(parseState_q));
    chk("count", 2, 16'(errCount_q));
    busDevClr = 1'b0;
    serialMode = 1'b1;
    rxValid = 1'b1;
    rxChar = 8'h03;
    tick();
    rxValid = 1'b0;
    wait_flush();
    rstCmd = 1'b1;
    tick();
    rstCmd = 1'b0;
    repeat (2) tick();
    chk("count", 2, 16'(errCount_q));
    pop_chk(16'hFF9B);
    clrStatus = 1'b1;
    tick();
    clrStatus = 1'b0;
    repeat (2) tick();
    chk("count", 0, 16'(errCount_q));
  endtask : s_clear
  initial begin
    {errPush, clrStatus, rstCmd, busDevClr, serialMode, rxValid, cmdStart, cmdDone, req} = '0;
    errCode = 16'h0;
    rxChar = 8'h00;
    sys_rst = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    chk("count", 0, 16'(errCount_q));
    chk("textLen", 16'h0050, 16'(textMaxLen_q));
    s_fifo();
    s_overflow();
    s_clear();
    tally_and_finish();
  end
endmodule : testbench
